// >>> inc/anp_pkg.sv
package anp_pkg;
    localparam int ANP_AW = 8;
    localparam int ANP_DW = 32;
    localparam int ANP_PW = 16;
    localparam int ANP_CW = 11;
    localparam int ANP_EW = 6;
    // Register byte offsets
    localparam logic [ANP_AW-1:0] ANP_OFS_PAGE = 8'h00;
    localparam logic [ANP_AW-1:0] ANP_OFS_STS = 8'h04;
    localparam logic [ANP_AW-1:0] ANP_OFS_MASK = 8'h08;
    localparam logic [ANP_AW-1:0] ANP_OFS_DEC = 8'h0C;
    localparam logic [ANP_AW-1:0] ANP_OFS_CTRL = 8'h10;
    // Received page fields
    localparam int ANP_BIT_MORE = 15;
    localparam int ANP_BIT_CONFIRM = 14;
    localparam int ANP_BIT_MP = 13;
    localparam int ANP_BIT_CONFIRM2 = 12;
    localparam int ANP_BIT_FLIP = 11;
    localparam int ANP_CODE_HI = 10;
    // Message codes
    localparam logic [ANP_CW-1:0] ANP_MSG_RSVD0 = 11'h000;
    localparam logic [ANP_CW-1:0] ANP_MSG_NULL = 11'h001;
    localparam logic [ANP_CW-1:0] ANP_MSG_EXT1 = 11'h002;
    localparam logic [ANP_CW-1:0] ANP_MSG_EXT2 = 11'h003;
    localparam logic [ANP_CW-1:0] ANP_MSG_RFNUM = 11'h004;
    // Remote-fault user codes
    localparam logic [ANP_CW-1:0] ANP_RF_TEST = 11'h000;
    localparam logic [ANP_CW-1:0] ANP_RF_LINK_LOSS = 11'h001;
    localparam logic [ANP_CW-1:0] ANP_RF_JABBER = 11'h002;
    localparam logic [ANP_CW-1:0] ANP_RF_PARALLEL_DETECT_ERROR = 11'h003;
    // Event bits in status and mask
    localparam int ANP_EV_PAGE = 0;
    localparam int ANP_EV_RSVD = 1;
    localparam int ANP_EV_RF = 2;
    localparam int ANP_EV_SEQ = 3;
    localparam int ANP_EV_DONE = 4;
    localparam int ANP_EV_NULL = 5;
    // Control fields
    localparam int ANP_CTRL_MORE = 0;
    localparam int ANP_CTRL_RF_LO = 1;
    localparam int ANP_CTRL_CODE_LO = 12;
    // Decode status fields
    localparam int ANP_DEC_PEND_LO = 11;
    localparam int ANP_DEC_RFPEND = 13;
    localparam int ANP_DEC_CNT_LO = 16;
    localparam logic [ANP_PW-1:0] ANP_PAGE_RST = 16'h0000;
    localparam logic [1:0] ANP_PEND_NONE = 2'h0;
    localparam logic [1:0] ANP_PEND_ONE = 2'h1;
    localparam logic [1:0] ANP_PEND_TWO = 2'h2;
endpackage

// >>> src/anp_top.sv
// Overview of operation
// - Bit 15 of the received page shows whether the partner has more next pages to send.
// - Bit 14 holds the handshake confirm bit, kept for the negotiation and meaningless to software.
// - Bit 13 is 1 when the stored page is a message page rather than an unformatted page.
// - Bit 12 holds the second confirm bit, internal only and to be ignored on read.
// - Bit 11 holds the page flip bit, internal only and to be ignored on read.
// - Bits 10 to 0 of a message page form the 11-bit message code.
// - Any undefined message code is reserved and never sent with a private meaning; here tx_msg_code carries any CTRL code unchecked while the more bit is set.
// - Message code zero is reserved and never sent as a meaningful message; a zero code written to CTRL still reaches tx_msg_code while the more bit is set.
// - A side with no more messages sends the null code one while its partner still sends pages.
// - Code two announces exactly one following unformatted page with an extended ability field.
// - Code three announces two following unformatted pages with extended ability fields.
// - Code four announces one following unformatted page whose user code is the fault number.
// - Fault user codes are 0 test, 1 link loss, 2 jabber and 3 parallel detect fault.
// - The exchange runs until neither the partner nor the local more-pages bit is set.
// - When both ends can do next pages each end sends at least one next page.
// - Announced unformatted pages come right after their message page in the defined order.
//
// Chosen here: the APB register port and the register addresses.
module anp_top
    import anp_pkg::*;
(
    input wire logic pclk, // APB clock, 20 MHz
    input wire logic presetn, // Asynchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ANP_AW-1:0] paddr, // APB byte address
    input wire logic [ANP_DW-1:0] pwdata, // APB write data
    output logic [ANP_DW-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic page_valid, // One-cycle strobe: whole page received
    input wire logic [ANP_PW-1:0] page_word, // Received page contents
    input wire logic parallel_detect_error, // Local parallel detect fault level
    output logic local_more_pages, // Local more-pages bit
    output logic [ANP_CW-1:0] tx_msg_code, // Message code for next sent page
    output logic [ANP_CW-1:0] tx_rf_user_code, // Fault user code to send
    output logic irq // Level interrupt
);
    import anp_pkg::*;

    function automatic logic code_defined(input logic [ANP_CW-1:0] c);
        code_defined = (c == ANP_MSG_NULL) || (c == ANP_MSG_EXT1) || (c == ANP_MSG_EXT2) || (c == ANP_MSG_RFNUM);
    endfunction

    function automatic logic [1:0] code_pending(input logic [ANP_CW-1:0] c);
        if (c == ANP_MSG_EXT2) begin
            code_pending = ANP_PEND_TWO;
        end else if (c == ANP_MSG_EXT1 || c == ANP_MSG_RFNUM) begin
            code_pending = ANP_PEND_ONE;
        end else begin
            code_pending = ANP_PEND_NONE;
        end
    endfunction

    // Bus state
    logic [ANP_DW-1:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [ANP_EW-1:0] sts_q, sts_d;
    logic [ANP_EW-1:0] mask_q, mask_d;
    logic ctrl_more_q, ctrl_more_d;
    logic [ANP_CW-1:0] ctrl_code_q, ctrl_code_d;
    logic [ANP_CW-1:0] ctrl_rf_q, ctrl_rf_d;
    logic irq_q, irq_d;
    // Decode state
    logic [ANP_PW-1:0] page_q, page_d;
    logic [1:0] pend_q, pend_d;
    logic rf_pend_q, rf_pend_d;
    logic [ANP_CW-1:0] rf_code_q, rf_code_d;
    logic [7:0] np_cnt_q, np_cnt_d;
    logic [ANP_CW-1:0] tx_code_q, tx_code_d;
    logic [ANP_CW-1:0] tx_rf_q, tx_rf_d;
    logic [ANP_EW-1:0] ev;

    logic setup, access, wr_acc, hit;
    logic [ANP_DW-1:0] rmux;
    logic is_msg;
    logic [ANP_CW-1:0] code;

    assign setup = psel && !penable && !pready_q;
    assign access = psel && penable && pready_q;
    assign wr_acc = access && pwrite && !pslverr_q;
    assign is_msg = page_word[ANP_BIT_MP];
    assign code = page_word[ANP_CODE_HI:0];
    assign hit = (paddr == ANP_OFS_PAGE) || (paddr == ANP_OFS_STS) || (paddr == ANP_OFS_MASK)
        || (paddr == ANP_OFS_DEC) || (paddr == ANP_OFS_CTRL);

    always_comb begin
        rmux = '0;
        case (paddr)
            ANP_OFS_PAGE: rmux[ANP_PW-1:0] = page_q;
            ANP_OFS_STS: rmux[ANP_EW-1:0] = sts_q;
            ANP_OFS_MASK: rmux[ANP_EW-1:0] = mask_q;
            ANP_OFS_DEC: begin
                rmux[ANP_CW-1:0] = rf_code_q;
                rmux[ANP_DEC_PEND_LO+:2] = pend_q;
                rmux[ANP_DEC_RFPEND] = rf_pend_q;
                rmux[ANP_DEC_CNT_LO+:8] = np_cnt_q;
            end
            ANP_OFS_CTRL: begin
                rmux[ANP_CTRL_MORE] = ctrl_more_q;
                rmux[ANP_CTRL_RF_LO+:ANP_CW] = ctrl_rf_q;
                rmux[ANP_CTRL_CODE_LO+:ANP_CW] = ctrl_code_q;
            end
            default: rmux = '0;
        endcase
    end

    // Decode of received pages
    always_comb begin
        page_d = page_q;
        pend_d = pend_q;
        rf_pend_d = rf_pend_q;
        rf_code_d = rf_code_q;
        np_cnt_d = np_cnt_q;
        ev = '0;
        if (page_valid) begin
            page_d = page_word;
            ev[ANP_EV_PAGE] = 1'b1;
            if (is_msg) begin
                if (pend_q != ANP_PEND_NONE) begin
                    ev[ANP_EV_SEQ] = 1'b1;
                end
                if (!code_defined(code)) begin
                    ev[ANP_EV_RSVD] = 1'b1;
                end
                if (code == ANP_MSG_NULL) begin
                    ev[ANP_EV_NULL] = 1'b1;
                end
                pend_d = code_pending(code);
                rf_pend_d = (code == ANP_MSG_RFNUM);
                if (np_cnt_q != 8'hFF) begin
                    np_cnt_d = np_cnt_q + 8'h01;
                end
            end else if (pend_q == ANP_PEND_NONE) begin
                ev[ANP_EV_SEQ] = 1'b1;
            end else begin
                pend_d = pend_q - 2'h1;
                if (rf_pend_q) begin
                    rf_code_d = code;
                    rf_pend_d = 1'b0;
                    ev[ANP_EV_RF] = 1'b1;
                end
            end
            if (!page_word[ANP_BIT_MORE] && !ctrl_more_q) begin
                ev[ANP_EV_DONE] = 1'b1;
                if (np_cnt_d == 8'h00) begin
                    ev[ANP_EV_SEQ] = 1'b1;
                end
                np_cnt_d = 8'h00;
            end
        end
        tx_code_d = ctrl_more_q ? ctrl_code_q : ANP_MSG_NULL;
        tx_rf_d = parallel_detect_error ? ANP_RF_PARALLEL_DETECT_ERROR : ctrl_rf_q;
    end

    // Bus and interrupt next state
    always_comb begin
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = setup ? !hit : 1'b0;
        mask_d = mask_q;
        ctrl_more_d = ctrl_more_q;
        ctrl_code_d = ctrl_code_q;
        ctrl_rf_d = ctrl_rf_q;
        sts_d = sts_q;
        if (setup && !pwrite) begin
            prdata_d = rmux;
        end
        if (wr_acc && paddr == ANP_OFS_STS) begin
            sts_d = sts_q & ~pwdata[ANP_EW-1:0];
        end
        // Set after clear so a new event is never lost
        sts_d = sts_d | ev;
        if (wr_acc && paddr == ANP_OFS_MASK) begin
            mask_d = pwdata[ANP_EW-1:0];
        end
        if (wr_acc && paddr == ANP_OFS_CTRL) begin
            ctrl_more_d = pwdata[ANP_CTRL_MORE];
            ctrl_rf_d = pwdata[ANP_CTRL_RF_LO+:ANP_CW];
            ctrl_code_d = pwdata[ANP_CTRL_CODE_LO+:ANP_CW];
        end
        irq_d = |(sts_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            sts_q <= '0;
            mask_q <= '0;
            ctrl_more_q <= 1'b0;
            ctrl_code_q <= ANP_MSG_NULL;
            ctrl_rf_q <= ANP_RF_TEST;
            irq_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            ctrl_more_q <= ctrl_more_d;
            ctrl_code_q <= ctrl_code_d;
            ctrl_rf_q <= ctrl_rf_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= ANP_PAGE_RST;
            pend_q <= ANP_PEND_NONE;
            rf_pend_q <= 1'b0;
            rf_code_q <= ANP_RF_TEST;
            np_cnt_q <= 8'h00;
            tx_code_q <= ANP_MSG_NULL;
            tx_rf_q <= ANP_RF_TEST;
        end else begin
            page_q <= page_d;
            pend_q <= pend_d;
            rf_pend_q <= rf_pend_d;
            rf_code_q <= rf_code_d;
            np_cnt_q <= np_cnt_d;
            tx_code_q <= tx_code_d;
            tx_rf_q <= tx_rf_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign local_more_pages = ctrl_more_q;
    assign tx_msg_code = tx_code_q;
    assign tx_rf_user_code = tx_rf_q;
    assign irq = irq_q;

    AST_PAGE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !page_valid |=> $stable(page_q)) else $error("page view changed without a page");
    AST_PAGE_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid |=> page_q[ANP_BIT_MORE] == $past(page_word[ANP_BIT_MORE])
            && page_q[ANP_BIT_MP] == $past(page_word[ANP_BIT_MP])) else $error("flag bits not captured");
    AST_CONFIRM_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid |=> page_q[ANP_BIT_CONFIRM:ANP_BIT_FLIP] == $past(page_word[ANP_BIT_CONFIRM:ANP_BIT_FLIP]))
        else $error("internal bits not captured");
    AST_CODE_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid |=> page_q[ANP_CODE_HI:0] == $past(page_word[ANP_CODE_HI:0])) else $error("code field wrong");
    AST_RSVD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid && is_msg && (code == ANP_MSG_RSVD0 || code > ANP_MSG_RFNUM) |=> sts_q[ANP_EV_RSVD])
        else $error("reserved code not flagged");
    AST_EXT2_PEND: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid && is_msg && code == ANP_MSG_EXT2 |=> pend_q == ANP_PEND_TWO) else $error("two pages not owed");
    AST_RF_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid && !is_msg && rf_pend_q && pend_q != ANP_PEND_NONE
        |=> rf_code_q == $past(code) && sts_q[ANP_EV_RF]) else $error("fault number not captured");
    AST_PD_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
        parallel_detect_error |=> tx_rf_user_code == ANP_RF_PARALLEL_DETECT_ERROR) else $error("pd fault code not sent");
    AST_NULL_TX: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_more_q |=> tx_msg_code == ANP_MSG_NULL) else $error("null not selected");
    AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid && !page_word[ANP_BIT_MORE] && !ctrl_more_q
        |=> sts_q[ANP_EV_DONE] && (irq || !mask_q[ANP_EV_DONE]))
        else $error("exchange end not reported");
    AST_UNANNOUNCED: assert property (@(posedge pclk) disable iff (!presetn)
        page_valid && !is_msg && pend_q == ANP_PEND_NONE |=> sts_q[ANP_EV_SEQ]) else $error("stray page missed");
endmodule

// >>> verification/anp_partner.sv
module anp_partner
    import anp_pkg::*;
(
    input wire logic pclk, // Shared clock
    output logic page_valid, // Whole page strobe
    output logic [ANP_PW-1:0] page_word // Page contents
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        page_valid = 1'b0;
        page_word = 16'h0000;
    end

    // caller picks codes
    // Word invalid after strobe, so show its inverse
    task automatic send(input logic [ANP_PW-1:0] w);
        page_valid <= 1'b1;
        page_word <= w;
        @(posedge pclk);
        page_valid <= 1'b0;
        page_word <= ~w;
        @(posedge pclk);
    endtask
endmodule

// >>> verification/anp_top_test.sv
module anp_top_test
    import anp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pde, lmp, irq, er;
    logic [ANP_AW-1:0] paddr;
    logic [ANP_DW-1:0] pwdata, prdata, rd;
    logic [ANP_CW-1:0] txc, txr;
    wire logic page_valid;
    wire logic [ANP_PW-1:0] page_word;
    int failures, n_tests;
    logic [15:0] wds [4] = '{16'hA000, 16'hA005, 16'hA7FF, 16'hA001};
    logic [31:0] exps [4] = '{32'h3, 32'h3, 32'h3, 32'h21};

    anp_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .page_valid(page_valid), .page_word(page_word), .parallel_detect_error(pde),
        .local_more_pages(lmp), .tx_msg_code(txc), .tx_rf_user_code(txr), .irq(irq));
    anp_partner part(.pclk(pclk), .page_valid(page_valid), .page_word(page_word));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called just after an edge; idle cycle at end avoids double drive
    task automatic apb(input logic w, input logic [ANP_AW-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [ANP_AW-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        conclude;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, pde} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        chk({21'h0, txc}, {21'h0, ANP_MSG_NULL});
        chk({30'h0, lmp, irq}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(ANP_OFS_PAGE, 32'h0);
        rd_chk(ANP_OFS_CTRL, 32'h0000_1000);
        $display("Test reset finished");
        part.send(16'hF804);
        rd_chk(ANP_OFS_PAGE, 32'h0000_F804);
        rd_chk(ANP_OFS_STS, 32'h1);
        rd_chk(ANP_OFS_DEC, 32'h0001_2800);
        part.send(16'h8002);
        rd_chk(ANP_OFS_PAGE, 32'h0000_8002);
        rd_chk(ANP_OFS_STS, 32'h5);
        rd_chk(ANP_OFS_DEC, 32'h0001_0002);
        $display("Test fault page finished");
        apb(1'b1, ANP_OFS_MASK, 32'h4);
        settle;
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        apb(1'b1, ANP_OFS_STS, 32'h4);
        settle;
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        rd_chk(ANP_OFS_STS, 32'h1);
        rd_chk(ANP_OFS_MASK, 32'h4);
        $display("Test interrupt finished");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ANP_OFS_STS, 32'h3F);
            part.send(wds[i]);
            rd_chk(ANP_OFS_STS, exps[i]);
        end
        part.send(16'hA002);
        rd_chk(ANP_OFS_DEC, 32'h0006_0802);
        part.send(16'h8000);
        part.send(16'hA003);
        rd_chk(ANP_OFS_DEC, 32'h0007_1002);
        apb(1'b1, ANP_OFS_STS, 32'h3F);
        part.send(16'hA001);
        rd_chk(ANP_OFS_STS, 32'h29);
        $display("Test message codes finished");
        do_reset;
        part.send(16'h2001);
        rd_chk(ANP_OFS_STS, 32'h31);
        rd_chk(ANP_OFS_DEC, 32'h0);
        apb(1'b1, ANP_OFS_PAGE, 32'hFFFF);
        rd_chk(ANP_OFS_PAGE, 32'h0000_2001);
        apb(1'b0, 8'h14, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, ANP_OFS_STS, 32'h3F);
        part.send(16'h2004);
        part.send(16'h0003);
        rd_chk(ANP_OFS_STS, 32'h1D);
        rd_chk(ANP_OFS_DEC, 32'h0000_0003);
        $display("Test done and access finished");
        apb(1'b1, ANP_OFS_CTRL, 32'h0012_3005);
        settle;
        chk({31'h0, lmp}, 32'h1);
        chk({21'h0, txc}, 32'h123);
        chk({21'h0, txr}, {21'h0, ANP_RF_JABBER});
        @(posedge pclk);
        apb(1'b1, ANP_OFS_STS, 32'h3F);
        part.send(16'h2001);
        rd_chk(ANP_OFS_STS, 32'h21);
        @(posedge pclk);
        pde <= 1'b1;
        settle;
        chk({21'h0, txr}, {21'h0, ANP_RF_PARALLEL_DETECT_ERROR});
        @(posedge pclk);
        apb(1'b1, ANP_OFS_CTRL, 32'h0012_3000);
        settle;
        chk({21'h0, txc}, {21'h0, ANP_MSG_NULL});
        @(posedge pclk);
        rd_chk(ANP_OFS_CTRL, 32'h0012_3000);
        $display("Test transmit control finished");
        conclude;
    end
endmodule
